/* File: apb_host_model.sv */
// Host-side APB master model for the counter bank
`timescale 1ns/1ps

module apb_host_model (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:0]      paddr_o,
  output logic [31:0]      pwdata_o
);
  import performance_monitor_pkg::*;

  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 12'h000;
    pwdata_o  = 32'h0000_0000;
  end

  // ----------------------------------------
  // Setup then access, held until pready
  // ----------------------------------------
  task automatic phase(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= w;
    paddr_o   <= a;
    pwdata_o  <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) @(posedge clk_i);
  endtask

  task automatic release_bus();
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
  endtask

  // One APB transfer, then idle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    phase(w, a, d);
    release_bus();
  endtask

  // High byte first, low byte setup straight after its access
  task automatic read_zv();
    @(posedge clk_i);
    phase(1'b0, ZV_HIGH_OFS, 32'h0);
    phase(1'b0, ZV_LOW_OFS, 32'h0);
    release_bus();
  endtask
endmodule

/* File: performance_monitor_error_counters.sv */
// Clear-on-read error counter bank with APB slave access
`timescale 1ns/1ps

module performance_monitor_error_counters (
  input  wire logic                     ref_clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     psel_i,
  input  wire logic                     penable_i,
  input  wire logic                     pwrite_i,
  input  wire logic [performance_monitor_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [performance_monitor_pkg::DATA_W-1:0] pwdata_i,
  input  wire performance_monitor_pkg::performance_monitor_events_s   events_i,
  output logic      [performance_monitor_pkg::DATA_W-1:0] prdata_o,
  output logic                          pready_o,
  output logic                          pslverr_o
);
  import performance_monitor_pkg::*;

  // ----------------------------------------------------------------
  // Saturating counter step
  // ----------------------------------------------------------------
  function automatic logic [7:0] cnt8_nxt(input logic [7:0] cnt,
                                          input logic       clr,
                                          input logic       ev);
    logic [7:0] res;
    res = cnt;
    if (clr) begin
      res = {7'h00, ev};
    end else if (ev && (cnt != 8'hff)) begin
      res = cnt + 8'h01;
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  reg_sel_e         sel;
  logic             setup;
  logic             rd_setup;
  logic             rd_zvh;
  logic             rd_zvl;
  logic [FCS_NUM-1:0] rd_fcs;
  logic [FCS_NUM-1:0] fcs_ev;
  logic             access;
  logic             wdata_seen;

  assign sel        = addr_decode(paddr_i);
  assign setup      = psel_i && !penable_i;
  assign rd_setup   = setup && !pwrite_i;
  assign access     = psel_i && penable_i;
  assign rd_zvh     = rd_setup && (sel == SEL_ZVH);
  assign rd_zvl     = rd_setup && (sel == SEL_ZVL);
  assign rd_fcs[0]  = rd_setup && (sel == SEL_FCS2);
  assign rd_fcs[1]  = rd_setup && (sel == SEL_FCS3);
  assign fcs_ev[0]  = events_i.fcs2;
  assign fcs_ev[1]  = events_i.fcs3;
  // Counters are read-only; write data is accepted and dropped
  assign wdata_seen = |pwdata_i;

  // ----------------------------------------------------------------
  // Zero violation counter
  // ----------------------------------------------------------------
  logic [ZV_W-1:0]  zv_cnt_r;
  logic [ZV_W-1:0]  zv_cnt_nxt;
  logic [CNT_W-1:0] zv_low_snap_r;
  logic             zv_armed_r;

  always_comb begin
    zv_cnt_nxt = zv_cnt_r;
    if (rd_zvh) begin
      zv_cnt_nxt = {15'h0000, events_i.ezv};
    end else if (events_i.ezv && (zv_cnt_r != 16'hffff)) begin
      zv_cnt_nxt = zv_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zv_cnt_r <= ZV_RST;
    end else begin
      zv_cnt_r <= zv_cnt_nxt;
    end
  end

  // High read freezes the low byte until the paired low read
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      zv_armed_r    <= 1'b0;
      zv_low_snap_r <= CNT_RST;
    end else if (rd_zvh) begin
      zv_armed_r    <= 1'b1;
      zv_low_snap_r <= zv_cnt_r[7:0];
    end else if (rd_zvl && zv_armed_r) begin
      zv_armed_r    <= 1'b0;
      zv_low_snap_r <= CNT_RST;
    end
  end

  // ----------------------------------------------------------------
  // FCS error counters, one per LAPD controller
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] fcs_cnt_r [FCS_NUM];

  for (genvar i = 0; i < FCS_NUM; i++) begin : g_fcs
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        fcs_cnt_r[i] <= CNT_RST;
      end else begin
        fcs_cnt_r[i] <= cnt8_nxt(fcs_cnt_r[i], rd_fcs[i], fcs_ev[i]);
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and error response
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] prdata_r;
  logic              slverr_r;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_r <= RDATA_RST;
    end else if (rd_setup) begin
      unique case (sel)
        SEL_ZVH:  prdata_r <= {24'h000000, zv_cnt_r[15:8]};
        SEL_ZVL:  prdata_r <= {24'h000000, zv_armed_r ? zv_low_snap_r : zv_cnt_r[7:0]};
        SEL_FCS2: prdata_r <= {24'h000000, fcs_cnt_r[0]};
        SEL_FCS3: prdata_r <= {24'h000000, fcs_cnt_r[1]};
        SEL_NONE: prdata_r <= RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slverr_r <= 1'b0;
    end else if (setup) begin
      slverr_r <= (sel == SEL_NONE) || (wdata_seen && 1'b0);
    end
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = 1'b1;
  assign pslverr_o = slverr_r && access;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_ZV_INC: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.ezv && !rd_zvh && (zv_cnt_r != 16'hffff))
      |=> (zv_cnt_r == $past(zv_cnt_r) + 16'h0001))
    else $error("zero violation count did not advance");

  AST_ZV_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (!events_i.ezv && !rd_zvh) |=> $stable(zv_cnt_r))
    else $error("zero violation count moved without cause");

  AST_ZV_HIGH_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_zvh |=> (zv_cnt_r == {15'h0000, $past(events_i.ezv)}))
    else $error("high byte read did not restart the count");

  AST_ZV_HIGH_DATA: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_zvh |=> (prdata_o == {24'h000000, $past(zv_cnt_r[15:8])}))
    else $error("high byte read returned wrong data");

  AST_ZV_PAIR: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_zvh ##1 (!rd_zvh && !rd_zvl) [*1] ##1 rd_zvl)
      |=> (prdata_o[7:0] == $past(zv_cnt_r[7:0], 3)))
    else $error("paired low read not coherent with high read");

  AST_ZV_ARM: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_zvh |=> zv_armed_r ##0 (zv_low_snap_r == $past(zv_cnt_r[7:0])))
    else $error("high byte read did not arm the low byte");

  AST_ZV_DISARM: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_zvl && zv_armed_r && !rd_zvh) |=> (!zv_armed_r && (zv_low_snap_r == CNT_RST)))
    else $error("low byte read did not complete the clear");

  AST_ZV_LOW_NOCLR: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_zvl && !zv_armed_r && !events_i.ezv) |=> $stable(zv_cnt_r))
    else $error("unpaired low read cleared the count");

  AST_FCS2_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_fcs[0] |=> ((prdata_o == {24'h000000, $past(fcs_cnt_r[0])})
                   && (fcs_cnt_r[0] == {7'h00, $past(events_i.fcs2)})))
    else $error("controller 2 counter read or clear wrong");

  AST_FCS3_CLEAR: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    rd_fcs[1] |=> ((prdata_o == {24'h000000, $past(fcs_cnt_r[1])})
                   && (fcs_cnt_r[1] == {7'h00, $past(events_i.fcs3)})))
    else $error("controller 3 counter read or clear wrong");

  AST_FCS_INC: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.fcs2 && !rd_fcs[0] && (fcs_cnt_r[0] != 8'hff))
      |=> (fcs_cnt_r[0] == $past(fcs_cnt_r[0]) + 8'h01))
    else $error("controller 2 counter did not advance");

  AST_CLEAR_EVENT: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_fcs[1] && events_i.fcs3) |=> (fcs_cnt_r[1] == 8'h01))
    else $error("event lost during clearing read");

  AST_SLVERR: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (setup && (sel == SEL_NONE)) |=> (access |-> pslverr_o))
    else $error("unmapped access not flagged");

  AST_MAPPED_NO_ERR: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (setup && (sel != SEL_NONE)) |=> (access |-> !pslverr_o))
    else $error("mapped access flagged as error");

  AST_UNMAPPED_RDATA: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_setup && (sel == SEL_NONE)) |=> (prdata_o == RDATA_RST))
    else $error("unmapped read returned nonzero data");

  AST_RDATA_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    !rd_setup |=> $stable(prdata_o))
    else $error("read data changed outside a read setup");

  // ----------------------------------------------------------------
  // Counter checks, LAPD controllers
  // ----------------------------------------------------------------
  AST_FCS3_INC: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (events_i.fcs3 && !rd_fcs[1] && (fcs_cnt_r[1] != 8'hff))
      |=> (fcs_cnt_r[1] == $past(fcs_cnt_r[1]) + 8'h01))
    else $error("controller 3 counter did not advance");

  AST_FCS2_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (!events_i.fcs2 && !rd_fcs[0]) |=> $stable(fcs_cnt_r[0]))
    else $error("controller 2 counter moved without cause");

  AST_FCS3_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (!events_i.fcs3 && !rd_fcs[1]) |=> $stable(fcs_cnt_r[1]))
    else $error("controller 3 counter moved without cause");

  AST_FCS2_SAT: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    ((fcs_cnt_r[0] == 8'hff) && !rd_fcs[0]) |=> (fcs_cnt_r[0] == 8'hff))
    else $error("controller 2 counter left saturation");

  AST_FCS3_SAT: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    ((fcs_cnt_r[1] == 8'hff) && !rd_fcs[1]) |=> (fcs_cnt_r[1] == 8'hff))
    else $error("controller 3 counter left saturation");

  AST_FCS2_CLEAR_EVENT: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_fcs[0] && events_i.fcs2) |=> (fcs_cnt_r[0] == 8'h01))
    else $error("controller 2 event lost during clearing read");

  // ----------------------------------------------------------------
  // Counter checks, zero violations
  // ----------------------------------------------------------------
  AST_ZV_CLEAR_EVENT: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_zvh && events_i.ezv) |=> (zv_cnt_r == 16'h0001))
    else $error("zero violation event lost during clearing read");

  AST_ZV_LOW_LIVE: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_zvl && !zv_armed_r) |=> (prdata_o == {24'h000000, $past(zv_cnt_r[7:0])}))
    else $error("unpaired low read returned wrong data");

  AST_ZV_LOW_SNAP: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_zvl && zv_armed_r) |=> (prdata_o == {24'h000000, $past(zv_low_snap_r)}))
    else $error("paired low read did not return the snapshot");

  AST_ZV_SNAP_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (zv_armed_r && !rd_zvh && !rd_zvl) |=> (zv_armed_r && $stable(zv_low_snap_r)))
    else $error("low byte snapshot changed while armed");

  AST_ZV_LOW_KEEP: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_zvl && !zv_armed_r) |=> !zv_armed_r)
    else $error("unpaired low read armed the pair");

endmodule

/* File: performance_monitor_pkg.sv */
// Package for the performance-monitor error counter bank
package performance_monitor_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam logic [11:0] ZV_HIGH_OFS = 12'h914;
  localparam logic [11:0] ZV_LOW_OFS  = 12'h918;
  localparam logic [11:0] FCS2_OFS    = 12'h91c;
  localparam logic [11:0] FCS3_OFS    = 12'h92c;

  // ----------------------------------------------------------------
  // Counter widths and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W       = 8;
  localparam int unsigned ZV_W        = 16;
  localparam int unsigned FCS_NUM     = 2;
  localparam logic [7:0]  CNT_RST     = 8'h00;
  localparam logic [15:0] ZV_RST      = 16'h0000;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ezv;
    logic fcs2;
    logic fcs3;
  } performance_monitor_events_s;

  typedef enum logic [4:0] {
    SEL_NONE = 5'b00001,
    SEL_ZVH  = 5'b00010,
    SEL_ZVL  = 5'b00100,
    SEL_FCS2 = 5'b01000,
    SEL_FCS3 = 5'b10000
  } reg_sel_e;

  function automatic reg_sel_e addr_decode(input logic [11:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    if (addr == ZV_HIGH_OFS) sel = SEL_ZVH;
    if (addr == ZV_LOW_OFS)  sel = SEL_ZVL;
    if (addr == FCS2_OFS)    sel = SEL_FCS2;
    if (addr == FCS3_OFS)    sel = SEL_FCS3;
    return sel;
  endfunction

endpackage

/* File: tb.sv */
// Self-checking testbench for the counter bank
`timescale 1ns/1ps

module tb;
  import performance_monitor_pkg::*;
  logic         ref_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata;
  performance_monitor_events_s ev;
  logic [32:0]  q[$];
  logic [32:0]  e;
  logic [7:0]   seed;
  int           n_fail, compares, n;

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  performance_monitor_error_counters dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .events_i(ev), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr));
  apb_host_model host (.clk_i(ref_clk_i), .pready_i(pready), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic rd(input logic [11:0] a, input logic [7:0] x, input logic err);
    q.push_back({err, 24'h0, x});
    seed = lfsr(seed);
    host.xfer(1'b0, a, {24'h0, seed});
  endtask

  task automatic wr(input logic [11:0] a, input logic err);
    q.push_back({err, 32'h0});
    seed = lfsr(seed);
    host.xfer(1'b1, a, {4{seed}});
  endtask

  task automatic zv(input logic [15:0] x);
    q.push_back({9'h000, 16'h0, x[15:8]});
    q.push_back({9'h000, 16'h0, x[7:0]});
    host.read_zv();
  endtask

  task automatic pulse(input logic [2:0] m, input int cnt);
    @(posedge ref_clk_i);
    ev <= performance_monitor_events_s'(m);
    repeat (cnt) @(posedge ref_clk_i);
    ev <= '0;
  endtask

  task automatic report_and_stop();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Oldest expectation against each completed transfer
  always @(posedge ref_clk_i) begin
    if (psel && penable && pready === 1'b1) begin
      compares++;
      if (q.size() == 0) begin
        n_fail++;
        $display("MISMATCH apb_queue exp=1 seen=0");
      end else begin
        e = q.pop_front();
        if (pslverr !== e[32] || (!pwrite && prdata !== e[31:0])) begin
          n_fail++;
          $display("MISMATCH apb@%h exp=%h seen=%h", paddr, e, {pslverr, prdata});
        end
      end
    end
  end

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_fail++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst_i   = 1'b0;
    ev       = '0;
    seed     = 8'h48;
    n_fail   = 0;
    compares = 0;
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(FCS2_OFS, CNT_RST, 1'b0);
    rd(FCS3_OFS, CNT_RST, 1'b0);
    zv(ZV_RST);
    seed = lfsr(seed);
    n = int'(seed[4:0]) + 1;
    pulse(3'b010, n);
    rd(FCS2_OFS, n[7:0], 1'b0);
    rd(FCS2_OFS, 8'h00, 1'b0);
    rd(FCS3_OFS, 8'h00, 1'b0);
    pulse(3'b011, 260);
    rd(FCS2_OFS, 8'hff, 1'b0);
    rd(FCS3_OFS, 8'hff, 1'b0);
    pulse(3'b100, 300);
    zv(16'h012c);
    zv(16'h0000);
    pulse(3'b100, 5);
    rd(ZV_LOW_OFS, 8'h05, 1'b0);
    rd(ZV_LOW_OFS, 8'h05, 1'b0);
    zv(16'h0005);
    fork
      zv(16'h0000);
      pulse(3'b100, 1);
    join
    zv(16'h0001);
    pulse(3'b010, 3);
    fork
      rd(FCS2_OFS, 8'h03, 1'b0);
      pulse(3'b010, 1);
    join
    rd(FCS2_OFS, 8'h01, 1'b0);
    rd(12'h900, 8'h00, 1'b1);
    wr(12'h900, 1'b1);
    pulse(3'b001, 2);
    wr(FCS3_OFS, 1'b0);
    rd(FCS3_OFS, 8'h02, 1'b0);
    pulse(3'b001, 4);
    fork
      rd(FCS3_OFS, 8'h04, 1'b0);
      pulse(3'b001, 1);
    join
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    rd(FCS3_OFS, 8'h00, 1'b0);
    repeat (3) @(posedge ref_clk_i);
    report_and_stop();
  end
endmodule
